// file: logic/flash_seq_regs.svh
// Purpose: Command codes, address map and timing counts of the flash sequencer
// Assumes: One machine cycle per clock, clock at 50 MHz
// Notes:   Definitions only; guarded against double inclusion
`ifndef FLASH_SEQ_REGS_SVH
`define FLASH_SEQ_REGS_SVH

// Command codes of the command field
`define CMD_READ         4'h0
`define CMD_VERIFY_OPT   4'h1
`define CMD_VERIFY_SEC   4'h2
`define CMD_VERIFY_UPPER 4'h3
`define CMD_RSVD_A       4'h4
`define CMD_RSVD_B       4'h8
`define CMD_WRITE_OPT    4'h9
`define CMD_WRITE_SEC    4'hA
`define CMD_WRITE_UPPER  4'hB
`define CMD_ERASE_OPT    4'hC
`define CMD_ERASE_SEC    4'hD
`define CMD_ERASE_UPPER  4'hE
`define CMD_SYS_RESET    4'hF

// Upper bank address window and index width
`define UPPER_BASE       16'h2000
`define UPPER_LAST       16'h3FFF
`define UPPER_AW         13
`define UPPER_BYTES      8192

// Security block: encryption array then the lock byte
`define SEC_ENC_BYTES    64
`define SEC_LOCK_ADDR    8'h40
`define SEC_BYTES        65
`define LOCK_BIT_HI      5
`define LOCK_BIT_MID     4
`define LOCK_BIT_LO      3

// Option control byte
`define WDOG_BIT         3
`define ERASED_BYTE      8'hFF

// Timing
`define CLK_MHZ          50
`define PROG_TIME_NS     20000
`define PROG_CYCLES      ((`PROG_TIME_NS * `CLK_MHZ + 999) / 1000)
`define ERASE_TIME_NS    400000
`define ERASE_CYCLES     ((`ERASE_TIME_NS * `CLK_MHZ + 999) / 1000)

`endif

// file: logic/flash_seq_pkg.sv
// Purpose: Types shared by the flash sequencer files
// Assumes: Constants come from flash_seq_regs.svh
// Notes:   Carriers for status and loader outputs
`include "flash_seq_regs.svh"

package flash_seq_pkg;

  // Sequencer activity
  typedef enum logic [1:0] {st_idle, st_prog, st_erase} seq_state_type;

  // Visible control register status
  typedef struct packed {
    logic       flash_idle_flag;     // High when no operation runs
    logic       flash_fault_flag;    // High after a failed operation
    logic [3:0] flash_command_field; // Current command
  } flash_status_type;

  // Loader mode outputs
  typedef struct packed {
    logic mode;        // Loader mode active
    logic rom_fetch;   // Fetch code from internal ROM
    logic serial0_sel; // Serial port 0 owned by loader
    logic autobaud_en; // Baud detection armed
    logic read_ok;     // Lock level allows verify
    logic write_ok;    // Lock level allows programming
  } loader_status_type;

endpackage : flash_seq_pkg

// file: logic/op_timer.sv
// Purpose: Down counter timing one self-timed flash operation
// Assumes: Load value of at least one
// Notes:   Done is a one-cycle pulse on the last counted cycle
`timescale 1ns/10ps

module op_timer #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Control
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] load,
  // Status
  output logic                  running,
  output logic                  done
);

  initial
  begin
    if (WIDTH < 2)
      $error("op_timer needs WIDTH of at least 2");
  end

  logic [WIDTH-1:0] count_q; // Cycles left

  // Count down from the load value
  always_ff @(posedge clk)
  begin
    if (reset)
      count_q <= '0;
    else if (start)
      count_q <= load;
    else if (count_q != '0)
      count_q <= count_q - 1'b1;
  end

  assign running = (count_q != '0);
  assign done    = (count_q == {{(WIDTH-1){1'b0}}, 1'b1});

endmodule : op_timer

// file: logic/loader_entry.sv
// Purpose: Detect the pin condition that enters serial loader mode
// Assumes: Pins are asynchronous to clk
// Notes:   Power-on reset or removing the pin condition leaves loader mode; pin reset holds it
`timescale 1ns/10ps

module loader_entry (
  // Clock and power-on reset
  input  wire logic clk,
  input  wire logic power_on_reset,
  // Pins
  input  wire logic rst_pin,
  input  wire logic external_access_pin_n,
  input  wire logic code_fetch_strobe_n,
  // Result
  output logic      mode_q
);

  logic [2:0] meta_q; // First synchroniser stage
  logic [2:0] sync_q; // Second synchroniser stage

  // Two-flop synchroniser for the three pins
  always_ff @(posedge clk)
  begin
    if (power_on_reset)
    begin
      meta_q <= 3'h6;
      sync_q <= 3'h6;
    end
    else
    begin
      meta_q <= {code_fetch_strobe_n, external_access_pin_n, rst_pin};
      sync_q <= meta_q;
    end
  end

  // Mode follows the condition; removing it or power-down leaves
  always_ff @(posedge clk)
  begin
    if (power_on_reset)
      mode_q <= 1'b0;
    else
      mode_q <= sync_q[0] & ~sync_q[1] & ~sync_q[2];
  end

endmodule : loader_entry

// file: logic/flash_in_application_command_sequencer.sv
// Purpose: In-application flash command sequencer with loader entry
// Assumes: One machine cycle per clk; writes are one-cycle strobes
// Notes:   Flash arrays are not cleared by reset; erase them first
`timescale 1ns/10ps
`include "flash_seq_regs.svh"

module flash_in_application_command_sequencer
  import flash_seq_pkg::*;
#(
  parameter int ERASE_CYCLES = `ERASE_CYCLES // Erase duration in clocks
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Control register write
  input  wire logic        ctrl_wr,
  input  wire logic [3:0]  ctrl_wdata,
  input  wire logic        timed_access_ok,
  // Data port
  input  wire logic        data_wr,
  input  wire logic [7:0]  data_wdata,
  output logic      [7:0]  data_rd_q,
  // Status
  output flash_status_type status,
  output logic             upper_exec_block,
  output logic             sys_reset_req_q,
  // Loader pins
  input  wire logic        power_on_reset,
  input  wire logic        rst_pin,
  input  wire logic        external_access_pin_n,
  input  wire logic        code_fetch_strobe_n,
  output loader_status_type loader
);

  localparam int TW = $clog2(ERASE_CYCLES + 1); // Timer width

  // Erase walk must cover the whole upper bank
  initial
  begin
    if (ERASE_CYCLES < `UPPER_BYTES)
      $error("ERASE_CYCLES too short to walk the upper bank");
  end

  // Bytes each command needs on the data port
  function automatic logic [1:0] bytes_needed(input logic [3:0] c);
    logic [1:0] n;
    n = 2'd0;
    case (c)
      `CMD_VERIFY_SEC:   n = 2'd1;
      `CMD_VERIFY_UPPER: n = 2'd2;
      `CMD_WRITE_OPT:    n = 2'd1;
      `CMD_WRITE_SEC:    n = 2'd2;
      `CMD_WRITE_UPPER:  n = 2'd3;
      default:           n = 2'd0;
    endcase
    return n;
  endfunction : bytes_needed

  // Whether a command arms an operation at all
  function automatic logic arms_op(input logic [3:0] c);
    logic a;
    a = 1'b0;
    case (c)
      `CMD_VERIFY_OPT, `CMD_VERIFY_SEC, `CMD_VERIFY_UPPER,
      `CMD_WRITE_OPT, `CMD_WRITE_SEC, `CMD_WRITE_UPPER,
      `CMD_ERASE_OPT, `CMD_ERASE_SEC, `CMD_ERASE_UPPER:
        a = 1'b1;
      default:
        a = 1'b0;
    endcase
    return a;
  endfunction : arms_op

  // Flash storage
  logic [7:0]            upper_mem [0:`UPPER_BYTES-1]; // Upper bank
  logic [7:0]            sec_mem   [0:`SEC_BYTES-1];   // Security block
  logic                  opt_wdog_q;                   // Option watchdog bit

  // Sequencer state
  logic [3:0]            cmd_q;      // Command field
  logic                  idle_q;     // Idle flag
  logic                  fault_q;    // Fault flag
  logic                  armed_q;    // Operation pending
  logic [1:0]            cnt_q;      // Data writes since command
  logic [7:0]            a_hi_q;     // First data byte
  logic [7:0]            a_lo_q;     // Second data byte
  seq_state_type         state_q;    // Activity
  logic [`UPPER_AW:0]    walk_q;     // Erase walk, top bit marks end

  // Decode
  logic                  cmd_ok;     // Command write taken
  logic [1:0]            need;       // Bytes the command needs
  logic                  go;         // Operation fires this cycle
  logic [15:0]           up_addr;    // Upper bank address
  logic [`UPPER_AW-1:0]  up_idx;     // Upper bank index
  logic                  up_in;      // Address inside upper window
  logic [7:0]            sec_addr;   // Security block address
  logic [6:0]            sec_idx;    // Security block index
  logic                  sec_in;     // Address inside security block
  logic [7:0]            up_rd;      // Upper byte read
  logic [7:0]            sec_rd;     // Security byte read
  logic [7:0]            sec_view;   // Security byte as presented
  logic [7:0]            opt_view;   // Option byte as presented
  logic                  bad;        // Operation fails
  logic                  is_write;   // Program command
  logic                  is_erase;   // Erase command
  logic                  walking;    // Erase walk active
  logic                  upper_we;   // Upper bank write
  logic [`UPPER_AW-1:0]  upper_wa;   // Upper bank write index
  logic [7:0]            upper_wd;   // Upper bank write data
  logic                  sec_we;     // Security write
  logic [6:0]            sec_wa;     // Security write index
  logic [7:0]            sec_wd;     // Security write data
  logic                  tmr_start;  // Timer load
  logic [TW-1:0]         tmr_load;   // Timer load value
  logic                  tmr_done;   // Timer end pulse
  logic                  ld_mode;    // Loader mode
  logic [7:0]            lock_byte;  // Stored lock byte

  // Commands are taken only when unlocked and idle
  assign cmd_ok = ctrl_wr & timed_access_ok & idle_q;

  // Fire once the last needed byte arrives, or at once if none
  assign need = bytes_needed(cmd_q);
  assign go   = armed_q & ((need == 2'd0) |
                (data_wr & (cnt_q == need - 2'd1)));

  // Address sources per command
  assign up_addr  = (cmd_q == `CMD_WRITE_UPPER) ? {a_hi_q, a_lo_q}
                                                : {a_hi_q, data_wdata};
  assign up_idx   = up_addr[`UPPER_AW-1:0];
  assign up_in    = (up_addr >= `UPPER_BASE) & (up_addr <= `UPPER_LAST);
  assign sec_addr = (cmd_q == `CMD_WRITE_SEC) ? a_hi_q : data_wdata;
  assign sec_idx  = sec_addr[6:0];
  assign sec_in   = (sec_addr <= `SEC_LOCK_ADDR);

  // Array reads
  assign up_rd  = upper_mem[up_idx];
  assign sec_rd = sec_in ? sec_mem[sec_idx] : `ERASED_BYTE;

  // Lock byte reads back with first lock bit on top
  always_comb
  begin
    sec_view = sec_rd;
    if (sec_addr == `SEC_LOCK_ADDR)
    begin
      sec_view[`LOCK_BIT_HI] = sec_rd[`LOCK_BIT_LO];
      sec_view[`LOCK_BIT_LO] = sec_rd[`LOCK_BIT_HI];
    end
  end

  // Option byte: unused bits read as one
  assign opt_view = {4'hF, opt_wdog_q, 3'h7};

  assign is_write = (cmd_q == `CMD_WRITE_OPT) | (cmd_q == `CMD_WRITE_SEC) |
                    (cmd_q == `CMD_WRITE_UPPER);
  assign is_erase = (cmd_q == `CMD_ERASE_OPT) | (cmd_q == `CMD_ERASE_SEC) |
                    (cmd_q == `CMD_ERASE_UPPER);

  // Failure: bad address, or programming a zero back to one
  always_comb
  begin
    bad = 1'b0;
    case (cmd_q)
      `CMD_VERIFY_SEC:
        bad = ~sec_in;
      `CMD_WRITE_SEC:
        bad = ~sec_in | ((sec_rd & data_wdata) != data_wdata);
      `CMD_VERIFY_UPPER:
        bad = ~up_in;
      `CMD_WRITE_UPPER:
        bad = ~up_in | ((up_rd & data_wdata) != data_wdata);
      `CMD_WRITE_OPT:
        bad = data_wdata[`WDOG_BIT] & ~opt_wdog_q;
      default:
        bad = 1'b0;
    endcase
  end

  // Command field; cleared by reset, not by power_on_reset, zero resumes reading
  always_ff @(posedge clk)
  begin
    if (reset)
      cmd_q <= `CMD_READ;
    else if (cmd_ok)
      cmd_q <= ctrl_wdata;
  end

  // Arming and data write count
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      armed_q <= 1'b0;
      cnt_q   <= 2'd0;
    end
    else if (cmd_ok)
    begin
      armed_q <= arms_op(ctrl_wdata);
      cnt_q   <= 2'd0;
    end
    else if (go)
      armed_q <= 1'b0;
    else if (data_wr & armed_q)
      cnt_q <= cnt_q + 2'd1;
  end

  // Latch the first two data bytes
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      a_hi_q <= 8'h00;
      a_lo_q <= 8'h00;
    end
    else if (data_wr & armed_q & ~go)
    begin
      if (cnt_q == 2'd0)
        a_hi_q <= data_wdata;
      else
        a_lo_q <= data_wdata;
    end
  end

  // Verify results appear on the data port the cycle after firing
  always_ff @(posedge clk)
  begin
    if (reset)
      data_rd_q <= `ERASED_BYTE;
    else if (go)
    begin
      case (cmd_q)
        `CMD_VERIFY_OPT:
          data_rd_q <= opt_view;
        `CMD_VERIFY_SEC:
          data_rd_q <= sec_view;
        `CMD_VERIFY_UPPER:
          data_rd_q <= up_in ? up_rd : `ERASED_BYTE;
        default:
          data_rd_q <= data_rd_q;
      endcase
    end
  end

  // Fault flag: new command clears it, a failure sets it and wins
  always_ff @(posedge clk)
  begin
    if (reset)
      fault_q <= 1'b0;
    else if (go & bad)
      fault_q <= 1'b1;
    else if (cmd_ok)
      fault_q <= 1'b0;
  end

  // Timer load for program and erase
  assign tmr_start = go & ~bad & (is_write | is_erase);
  assign tmr_load  = is_erase ? TW'(ERASE_CYCLES) : TW'(`PROG_CYCLES);

  // Activity and idle flag
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= st_idle;
      idle_q  <= 1'b1;
    end
    else
    begin
      unique case (state_q)
        st_idle:
        begin
          if (tmr_start)
          begin
            state_q <= is_erase ? st_erase : st_prog;
            idle_q  <= 1'b0;
          end
        end
        st_prog, st_erase:
        begin
          if (tmr_done)
          begin
            state_q <= st_idle;
            idle_q  <= 1'b1;
          end
        end
      endcase
    end
  end

  // Erase walk over every location
  always_ff @(posedge clk)
  begin
    if (reset)
      walk_q <= '0;
    else if (tmr_start)
      walk_q <= '0;
    else if (walking)
      walk_q <= walk_q + 1'b1;
  end

  assign walking = (state_q == st_erase) & ~walk_q[`UPPER_AW];

  // Upper bank write port
  always_comb
  begin
    upper_we = 1'b0;
    upper_wa = up_idx;
    upper_wd = data_wdata;
    if (go & ~bad & (cmd_q == `CMD_WRITE_UPPER))
      upper_we = 1'b1;
    else if (walking & (cmd_q == `CMD_ERASE_UPPER))
    begin
      upper_we = 1'b1;
      upper_wa = walk_q[`UPPER_AW-1:0];
      upper_wd = `ERASED_BYTE;
    end
  end

  // Upper bank storage
  always_ff @(posedge clk)
  begin
    if (upper_we)
      upper_mem[upper_wa] <= upper_wd;
  end

  // Security block write port
  always_comb
  begin
    sec_we = 1'b0;
    sec_wa = sec_idx;
    sec_wd = data_wdata;
    if (go & ~bad & (cmd_q == `CMD_WRITE_SEC))
      sec_we = 1'b1;
    else if (walking & (cmd_q == `CMD_ERASE_SEC) &
             (walk_q < (`UPPER_AW+1)'(`SEC_BYTES)))
    begin
      sec_we = 1'b1;
      sec_wa = walk_q[6:0];
      sec_wd = `ERASED_BYTE;
    end
  end

  // Security block storage
  always_ff @(posedge clk)
  begin
    if (sec_we)
      sec_mem[sec_wa] <= sec_wd;
  end

  // Option watchdog bit, kept in flash across resets
  always_ff @(posedge clk)
  begin
    if (go & ~bad & (cmd_q == `CMD_WRITE_OPT))
      opt_wdog_q <= data_wdata[`WDOG_BIT];
    else if (go & (cmd_q == `CMD_ERASE_OPT))
      opt_wdog_q <= 1'b1;
  end

  // System reset request pulse
  always_ff @(posedge clk)
  begin
    if (reset)
      sys_reset_req_q <= 1'b0;
    else
      sys_reset_req_q <= cmd_ok & (ctrl_wdata == `CMD_SYS_RESET);
  end

  // Self-timed operation length
  op_timer #(
    .WIDTH (TW)
  ) u_timer (
    .clk     (clk),
    .reset   (reset),
    .start   (tmr_start),
    .load    (tmr_load),
    .running (),
    .done    (tmr_done)
  );

  // Loader pin condition
  loader_entry u_loader (
    .clk                   (clk),
    .power_on_reset        (power_on_reset),
    .rst_pin               (rst_pin),
    .external_access_pin_n (external_access_pin_n),
    .code_fetch_strobe_n   (code_fetch_strobe_n),
    .mode_q                (ld_mode)
  );

  // Upper bank execution only in read mode
  assign upper_exec_block = (cmd_q != `CMD_READ);

  // Status outputs
  assign status.flash_idle_flag     = idle_q;
  assign status.flash_fault_flag    = fault_q;
  assign status.flash_command_field = cmd_q;

  // Loader outputs and lock-level access limits
  assign lock_byte          = sec_mem[`SEC_BYTES-1];
  assign loader.mode        = ld_mode;
  assign loader.rom_fetch   = ld_mode;
  assign loader.serial0_sel = ld_mode;
  assign loader.autobaud_en = ld_mode;
  assign loader.read_ok     = ld_mode & lock_byte[`LOCK_BIT_MID] &
                              lock_byte[`LOCK_BIT_HI];
  assign loader.write_ok    = ld_mode & lock_byte[`LOCK_BIT_LO] &
                              lock_byte[`LOCK_BIT_MID] &
                              lock_byte[`LOCK_BIT_HI];

endmodule : flash_in_application_command_sequencer

// file: bench/seq_chk.sv
// Purpose: Port-level checks of the flash command sequencer
// Assumes: Single clock; reset and power_on_reset synchronous, active high
// Notes:   Bound to every instance of the sequencer
`timescale 1ns/10ps

module seq_chk
  import flash_seq_pkg::*;
(
  // Clock and resets
  input wire logic              clk,
  input wire logic              reset,
  input wire logic              power_on_reset,
  // Control and data port
  input wire logic              ctrl_wr,
  input wire logic [3:0]        ctrl_wdata,
  input wire logic              timed_access_ok,
  input wire logic              data_wr,
  input wire logic [7:0]        data_wdata,
  input wire logic [7:0]        data_rd_q,
  // Status and loader
  input wire flash_status_type  status,
  input wire logic              upper_exec_block,
  input wire logic              sys_reset_req_q,
  input wire logic              rst_pin,
  input wire logic              external_access_pin_n,
  input wire logic              code_fetch_strobe_n,
  input wire loader_status_type loader
);
  // Execution block follows the command field
  exec_blk_a: assert property (@(posedge clk) disable iff (reset)
    upper_exec_block == (status.flash_command_field != 4'h0)) else $error("exec block wrong");
  // Accepted command lands next cycle
  cmd_take_a: assert property (@(posedge clk) disable iff (reset)
    ctrl_wr && timed_access_ok && status.flash_idle_flag |=>
    status.flash_command_field == $past(ctrl_wdata)) else $error("command not taken");
  // Refused command leaves the field alone
  cmd_hold_a: assert property (@(posedge clk) disable iff (reset)
    !(ctrl_wr && timed_access_ok && status.flash_idle_flag) |=>
    $stable(status.flash_command_field)) else $error("command field moved");
  // Reset clears field, fault flag and reset request, sets idle flag and read byte to FF
  reset_clr_a: assert property (@(posedge clk) reset |=>
    status == {1'b1, 1'b0, 4'h0} && data_rd_q == 8'hFF && !sys_reset_req_q)
    else $error("reset state wrong");
  // Busy never a glitch
  busy_span_a: assert property (@(posedge clk) disable iff (reset)
    $fell(status.flash_idle_flag) |-> !status.flash_idle_flag [*8]) else $error("busy too short");
  // System reset request is a single pulse under code F
  sys_pulse_a: assert property (@(posedge clk) disable iff (reset)
    sys_reset_req_q |-> status.flash_command_field == 4'hF ##1 !sys_reset_req_q)
    else $error("reset request wrong");
  // Option verify returns fixed ones around the watchdog bit
  opt_read_a: assert property (@(posedge clk) disable iff (reset)
    ctrl_wr && timed_access_ok && status.flash_idle_flag && ctrl_wdata == 4'h1 |->
    ##2 data_rd_q[7:4] == 4'hF && data_rd_q[2:0] == 3'h7) else $error("option read wrong");
  // Loader mode owns ROM fetch, serial port and baud detection
  loader_out_a: assert property (@(posedge clk) disable iff (power_on_reset)
    loader.mode |-> loader.rom_fetch && loader.serial0_sel && loader.autobaud_en)
    else $error("loader outputs wrong");
  // Pin condition held three edges enters loader mode
  loader_in_a: assert property (@(posedge clk) disable iff (power_on_reset)
    (rst_pin && !external_access_pin_n && !code_fetch_strobe_n) [*3] |=> loader.mode)
    else $error("loader not entered");
endmodule : seq_chk

bind flash_in_application_command_sequencer seq_chk u_seq_chk (
  .clk(clk), .reset(reset), .power_on_reset(power_on_reset), .ctrl_wr(ctrl_wr),
  .ctrl_wdata(ctrl_wdata), .timed_access_ok(timed_access_ok), .data_wr(data_wr),
  .data_wdata(data_wdata), .data_rd_q(data_rd_q), .status(status),
  .upper_exec_block(upper_exec_block), .sys_reset_req_q(sys_reset_req_q),
  .rst_pin(rst_pin), .external_access_pin_n(external_access_pin_n),
  .code_fetch_strobe_n(code_fetch_strobe_n), .loader(loader));

// file: bench/flash_in_application_command_sequencer_tb.sv
// Purpose: Self-checking bench of the flash command sequencer
// Assumes: Inputs change at the falling edge; erase shortened to 8192 clocks
// Notes:   Arrays start unknown, so erases run before any verify
`timescale 1ns/10ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module flash_in_application_command_sequencer_tb;
  import flash_seq_pkg::*;
  localparam int ER = 8192; // Shortened erase time
  localparam int PR = 1000; // Program time
  logic clk = 0, reset = 1, ctrl_wr = 0, timed_access_ok = 0, data_wr = 0;
  logic power_on_reset = 1, rst_pin = 0, ea_n = 1, code_fetch_strobe_n_n = 1;
  logic [3:0] ctrl_wdata = 4'h0;
  logic [7:0] data_wdata = 8'h00, data_rd_q;
  logic upper_exec_block, sys_reset_req_q;
  flash_status_type  status;
  loader_status_type loader;
  int n_mismatch = 0, cmp_count = 0;

  // Device under test
  flash_in_application_command_sequencer #(.ERASE_CYCLES(ER))
    u_flash_in_application_command_sequencer (
    .clk(clk), .reset(reset), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
    .timed_access_ok(timed_access_ok), .data_wr(data_wr), .data_wdata(data_wdata),
    .data_rd_q(data_rd_q), .status(status), .upper_exec_block(upper_exec_block),
    .sys_reset_req_q(sys_reset_req_q), .power_on_reset(power_on_reset), .rst_pin(rst_pin),
    .external_access_pin_n(ea_n), .code_fetch_strobe_n(code_fetch_strobe_n_n), .loader(loader));

  // 50 MHz clock
  always #10 clk = ~clk;

  // One command write, with or without the unlock window
  task cmd(input logic [3:0] c, input logic ta);
    @(negedge clk);
    ctrl_wr = 1; ctrl_wdata = c; timed_access_ok = ta;
    @(negedge clk);
    ctrl_wr = 0; timed_access_ok = 0;
  endtask : cmd

  // One data port write
  task dw(input logic [7:0] b);
    @(negedge clk);
    data_wr = 1; data_wdata = b;
    @(negedge clk);
    data_wr = 0;
  endtask : dw

  // Wait for busy, then time it against the expected span
  task run_busy(input int exp_n);
    int n, w;
    n = 0; w = 0;
    while (status.flash_idle_flag === 1'b1 && w < 6) begin @(negedge clk); w++; end
    while (status.flash_idle_flag !== 1'b1 && n < 30000) begin @(negedge clk); n++; end
    `CHK("busy span", 1'b1, (n >= exp_n - 3 && n <= exp_n + 3))
  endtask : run_busy

  // Verify a location; the command picks the addr count
  task verify(input logic [3:0] c, input logic [15:0] a, input logic [7:0] e);
    cmd(c, 1);
    if (c == 4'h3) dw(a[15:8]);
    if (c != 4'h1) dw(a[7:0]);
    repeat (2) @(negedge clk);
    `CHK("verify byte", e, data_rd_q)
  endtask : verify

  // Reset state and refused, ignored and erase commands
  task t_erase;
    `CHK("reset status", 6'h20, status)
    `CHK("reset read", 8'hFF, data_rd_q)
    cmd(4'hE, 0);
    `CHK("locked cmd", 4'h0, status.flash_command_field)
    cmd(4'hE, 1);
    `CHK("exec block", 1'b1, upper_exec_block)
    @(negedge clk);
    cmd(4'hD, 1);
    `CHK("busy cmd", 4'hE, status.flash_command_field)
    run_busy(ER - 3);
    cmd(4'hD, 1);
    run_busy(ER);
    cmd(4'hC, 1);
    run_busy(ER);
    verify(4'h1, 16'h0, 8'hFF);
    verify(4'h2, 16'h0040, 8'hFF);
    verify(4'h3, 16'h2000, 8'hFF);
  endtask : t_erase

  // Program upper, option and security, then a bad address
  task t_prog;
    cmd(4'hB, 1);
    dw(8'h3F); dw(8'hFF); dw(8'hA5);
    run_busy(PR);
    dw(8'h00);
    repeat (3) @(negedge clk);
    `CHK("no rearm", 1'b1, status.flash_idle_flag)
    verify(4'h3, 16'h3FFF, 8'hA5);
    cmd(4'h9, 1);
    dw(8'hF7);
    run_busy(PR);
    verify(4'h1, 16'h0, 8'hF7);
    cmd(4'hA, 1);
    dw(8'h05); dw(8'h3C);
    run_busy(PR);
    verify(4'h2, 16'h0005, 8'h3C);
    cmd(4'hA, 1);
    dw(8'h40);
    dw(8'hF7);
    run_busy(PR);
    verify(4'h2, 16'h0040, 8'hDF);
    cmd(4'hB, 1);
    dw(8'h40); dw(8'h00); dw(8'h00);
    repeat (2) @(negedge clk);
    `CHK("fault flags", 2'b11, status[5:4])
  endtask : t_prog

  // System reset request, reset inside an erase, restart, read mode, loader
  task t_sys;
    int p;
    cmd(4'hF, 1);
    p = sys_reset_req_q;
    repeat (3) begin @(negedge clk); p += sys_reset_req_q; end
    `CHK("reset pulse", 1, p)
    cmd(4'hC, 1);
    repeat (20) @(negedge clk);
    `CHK("erase running", 1'b0, status.flash_idle_flag)
    reset = 1;
    repeat (4) @(negedge clk);
    reset = 0;
    `CHK("cleared cmd", 4'h0, status.flash_command_field)
    `CHK("idle after reset", 1'b1, status.flash_idle_flag)
    cmd(4'hC, 1);
    run_busy(ER);
    verify(4'h1, 16'h0, 8'hFF);
    cmd(4'h0, 1);
    `CHK("read mode", 4'h0, status.flash_command_field)
    `CHK("exec free", 1'b0, upper_exec_block)
    rst_pin = 1; ea_n = 0; code_fetch_strobe_n_n = 0;
    repeat (4) @(negedge clk);
    `CHK("loader on", 6'h3E, loader)
    code_fetch_strobe_n_n = 1;
    repeat (4) @(negedge clk);
    `CHK("loader off", 1'b0, loader.mode)
  endtask : t_sys

  // Verdict and end of run
  task close_out;
    $display("Checks %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  // Main sequence
  initial
  begin
    repeat (4) @(negedge clk);
    reset = 0; power_on_reset = 0;
    t_erase;
    t_prog;
    t_sys;
    close_out;
  end

  // Watchdog against a hang
  initial
  begin
    #(20 * 60000);
    n_mismatch++;
    close_out;
  end
endmodule : flash_in_application_command_sequencer_tb
